/* hdl/cause_decoder.sv */
`timescale 1ns/1ps
module cause_decoder import rsi_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic por_bor_evt,
    input wire logic master_clear_pin_evt,
    input wire logic wdt_rst_evt,
    input wire logic wake_irq_evt,
    input wire logic wake_wdt_evt,
    input wire wake_src_t wake_src,
    output cause_cls_t cls_q,
    output logic wake_irq_q,
    output wake_src_t wake_src_q
);

    cause_cls_t cls_d;
    logic wake_irq_d;
    wake_src_t wake_src_d;

    // ==========================================================
    // priority: power-on, then clear or watchdog, then wake
    // ==========================================================
    always_comb begin
        cls_d = CLS_NONE;
        wake_irq_d = 1'b0;
        wake_src_d = wake_src;
        if (por_bor_evt) begin
            cls_d = CLS_POR;
        end else if (master_clear_pin_evt || wdt_rst_evt) begin
            cls_d = CLS_MASTER_CLEAR_PIN;
        end else if (wake_irq_evt || wake_wdt_evt) begin
            cls_d = CLS_WAKE;
            wake_irq_d = wake_irq_evt;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cls_q <= CLS_NONE;
            wake_irq_q <= 1'b0;
            wake_src_q <= '0;
        end else if (clk_en) begin
            cls_q <= cls_d;
            wake_irq_q <= wake_irq_d;
            wake_src_q <= wake_src_d;
        end
    end

endmodule

/* hdl/reset_state_initializer.sv */
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// How it works
// R1: resets set port D direction all ones
// R2: resets load port E direction 0000_-111
// R3: resets clear irq enable 1, wake keeps
// R4: resets clear irq enable 2 bit
// R5: power-on clears upper power status bit only
// R6: power-on clears aux flag bit only
// R7: timer period all ones, even on wake
// R8: resets clear serial address or rate
// R9: resets clear six serial state bits
// R10: resets load transmit control 0000_-010
// R11: resets clear baud rate divisor
// R12: unimplemented bits always read zero
// R13: interrupt wake sets a source flag
// R14: irq wake with enable: pc+1, then vector
// R15: every reset clears global irq enable
// R16: decode cause into three value columns
module reset_state_initializer import rsi_pkg::*; #(
    parameter int PC_W = 13
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic por_bor_evt,
    input wire logic master_clear_pin_evt,
    input wire logic wdt_rst_evt,
    input wire logic wake_irq_evt,
    input wire logic wake_wdt_evt,
    input wire wake_src_t wake_src,
    input wire logic core_step,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output sfr_arr_t sfr_state,
    output logic exec_next,
    output logic vector_load,
    output logic [PC_W-1:0] vector_addr,
    output logic irq
);

    initial begin
        if (PC_W < 3 || PC_W > 16) begin
            $error("reset_state_initializer: PC_W out of range");
        end
    end

    // ==========================================================
    // helpers
    // ==========================================================
    function automatic logic [IDX_W-1:0] reg_index(
        input logic [ADDR_W-1:0] addr
    );
        logic [ADDR_W-3:0] word;
        word = addr[ADDR_W-1:2];
        if (addr[1:0] != 2'b00 || word >= ADDR_W'(SFR_N)) begin
            reg_index = IDX_NONE;
        end else begin
            reg_index = word[IDX_W-1:0];
        end
    endfunction

    function automatic sfr_arr_t apply_col(
        input sfr_arr_t cur,
        input sfr_arr_t keep
    );
        apply_col = ((cur & keep) | (RESET_VAL & ~keep)) & IMPL_MASK;
    endfunction

    // ==========================================================
    // sub-blocks
    // ==========================================================
    cause_cls_t cls;
    logic wake_irq;
    wake_src_t wake_src_r;
    logic vec_start;
    logic vec_busy;
    logic vec_exec_next;
    logic vec_load;
    logic [PC_W-1:0] vec_addr;

    cause_decoder u_cause (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .por_bor_evt(por_bor_evt),
        .master_clear_pin_evt(master_clear_pin_evt),
        .wdt_rst_evt(wdt_rst_evt),
        .wake_irq_evt(wake_irq_evt),
        .wake_wdt_evt(wake_wdt_evt),
        .wake_src(wake_src),
        .cls_q(cls),
        .wake_irq_q(wake_irq),
        .wake_src_q(wake_src_r)
    );

    wake_vector #(
        .PC_W(PC_W)
    ) u_vector (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .start(vec_start),
        .core_step(core_step),
        .exec_next_q(vec_exec_next),
        .vector_load_q(vec_load),
        .vector_addr_q(vec_addr),
        .busy_q(vec_busy)
    );

    assign exec_next = vec_exec_next;
    assign vector_load = vec_load;
    assign vector_addr = vec_addr;

    // ==========================================================
    // state
    // ==========================================================
    sfr_arr_t sfr_q, sfr_d;
    logic [ST_W-1:0] st_q, st_d;
    logic [ST_W-1:0] mask_q, mask_d;
    logic [1:0] last_cls_q, last_cls_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic ready_q, ready_d;
    logic err_q, err_d;
    logic irq_q, irq_d;

    logic setup, commit;
    logic [IDX_W-1:0] idx;
    logic mapped;

    assign setup = psel && !penable;
    assign commit = psel && penable && ready_q;
    assign idx = reg_index(paddr);
    assign mapped = (idx != IDX_NONE) || paddr == OFF_IRQ_STATUS
        || paddr == OFF_IRQ_MASK || paddr == OFF_CAUSE;
    assign vec_start = cls == CLS_WAKE && wake_irq
        && sfr_q[IDX_IRQ_CORE][GIE_BIT] && !vec_busy; // R14

    // ==========================================================
    // register update
    // ==========================================================
    always_comb begin
        sfr_d = sfr_q;
        st_d = st_q;
        mask_d = mask_q;
        last_cls_d = last_cls_q;
        // software access first, so that hardware events win
        if (commit && pwrite) begin
            if (idx != IDX_NONE) begin
                sfr_d[idx] = pwdata[7:0] & IMPL_MASK[idx]; // R12
            end else if (paddr == OFF_IRQ_MASK) begin
                mask_d = pwdata[ST_W-1:0];
            end
        end
        if (commit && !pwrite && paddr == OFF_IRQ_STATUS) begin
            // clear only the bits reported, a later event stays set
            st_d = st_q & ~rdata_q[ST_W-1:0];
        end
        unique case (cls)
            CLS_POR: begin
                // R1 R2 R3 R4 R5 R6 R7 R8 R9 R10 R11 R15 R16
                sfr_d = apply_col(sfr_q, KEEP_POR);
                st_d[ST_POR] = 1'b1;
                last_cls_d = 2'd1;
            end
            CLS_MASTER_CLEAR_PIN: begin
                // R1 R2 R3 R4 R5 R6 R7 R8 R9 R10 R11 R15 R16
                sfr_d = apply_col(sfr_q, KEEP_MASTER_CLEAR_PIN);
                st_d[ST_MASTER_CLEAR_PIN] = 1'b1;
                last_cls_d = 2'd2;
            end
            CLS_WAKE: begin
                sfr_d = apply_col(sfr_d, KEEP_WAKE); // R7 R16
                st_d[ST_WAKE] = 1'b1;
                last_cls_d = 2'd3;
                if (wake_irq) begin
                    unique case (wake_src_r.reg_sel)
                        SRC_IRQ_CORE: begin
                            sfr_d[IDX_IRQ_CORE][wake_src_r.bit_sel] =
                                1'b1; // R13
                        end
                        SRC_PERIPHERAL_IRQ_FLAGS_1: begin
                            sfr_d[IDX_PERIPHERAL_IRQ_FLAGS_1][wake_src_r.bit_sel] =
                                1'b1; // R13
                        end
                        default: begin
                            sfr_d[IDX_PERIPHERAL_IRQ_FLAGS_2][0] = 1'b1; // R13
                        end
                    endcase
                end
            end
            CLS_NONE: begin
            end
        endcase
        if (vec_load) begin
            st_d[ST_VECTOR] = 1'b1;
        end
    end

    // ==========================================================
    // bus answer
    // ==========================================================
    always_comb begin
        rdata_d = '0;
        ready_d = 1'b0;
        err_d = 1'b0;
        if (setup) begin
            ready_d = 1'b1;
            err_d = !mapped;
            if (idx != IDX_NONE) begin
                rdata_d[7:0] = sfr_q[idx] & IMPL_MASK[idx]; // R12
            end else if (paddr == OFF_IRQ_STATUS) begin
                rdata_d[ST_W-1:0] = st_q;
            end else if (paddr == OFF_IRQ_MASK) begin
                rdata_d[ST_W-1:0] = mask_q;
            end else if (paddr == OFF_CAUSE) begin
                rdata_d[2:0] = {vec_busy, last_cls_q};
            end
        end else if (psel && penable && !ready_q) begin
            ready_d = 1'b1;
            err_d = !mapped;
            rdata_d = rdata_q;
        end
        irq_d = |(st_d & mask_d);
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sfr_q <= RESET_VAL & IMPL_MASK;
            st_q <= '0;
            mask_q <= '0;
            last_cls_q <= 2'd1;
            rdata_q <= '0;
            ready_q <= 1'b0;
            err_q <= 1'b0;
            irq_q <= 1'b0;
        end else if (clk_en) begin
            sfr_q <= sfr_d;
            st_q <= st_d;
            mask_q <= mask_d;
            last_cls_q <= last_cls_d;
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            err_q <= err_d;
            irq_q <= irq_d;
        end
    end

    assign prdata = rdata_q;
    assign pready = ready_q;
    assign pslverr = err_q;
    assign sfr_state = sfr_q;
    assign irq = irq_q;

endmodule

/* hdl/wake_vector.sv */
`timescale 1ns/1ps
module wake_vector import rsi_pkg::*; #(
    parameter int PC_W = 13
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic start,
    input wire logic core_step,
    output logic exec_next_q,
    output logic vector_load_q,
    output logic [PC_W-1:0] vector_addr_q,
    output logic busy_q
);

    initial begin
        if (PC_W < 3 || PC_W > 16) begin
            $error("wake_vector: PC_W out of range");
        end
    end

    typedef enum logic [1:0] {
        VEC_IDLE,
        VEC_NEXT,
        VEC_WAIT
    } vec_state_t;

    vec_state_t state_q, state_d;
    logic exec_next_d, vector_load_d, busy_d;
    logic [PC_W-1:0] vector_addr_d;

    // ==========================================================
    // run pc+1 first, then load the vector
    // ==========================================================
    always_comb begin
        state_d = state_q;
        exec_next_d = 1'b0;
        vector_load_d = 1'b0;
        vector_addr_d = vector_addr_q;
        unique case (state_q)
            VEC_IDLE: begin
                if (start) begin
                    state_d = VEC_NEXT;
                    exec_next_d = 1'b1;
                end
            end
            VEC_NEXT: begin
                state_d = VEC_WAIT;
            end
            VEC_WAIT: begin
                if (core_step) begin
                    state_d = VEC_IDLE;
                    vector_load_d = 1'b1;
                    vector_addr_d = IRQ_VECTOR[PC_W-1:0];
                end
            end
        endcase
        busy_d = (state_d != VEC_IDLE);
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= VEC_IDLE;
            exec_next_q <= 1'b0;
            vector_load_q <= 1'b0;
            vector_addr_q <= '0;
            busy_q <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            exec_next_q <= exec_next_d;
            vector_load_q <= vector_load_d;
            vector_addr_q <= vector_addr_d;
            busy_q <= busy_d;
        end
    end

endmodule

/* pkg/rsi_pkg.sv */
package rsi_pkg;

    // ==========================================================
    // bus and register map
    // ==========================================================
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SFR_N = 14;
    localparam int IDX_W = 5;

    localparam logic [IDX_W-1:0] IDX_PORT_D_DIR = 5'h00;
    localparam logic [IDX_W-1:0] IDX_PORT_E_DIR = 5'h01;
    localparam logic [IDX_W-1:0] IDX_PERIPHERAL_IRQ_ENABLE_1 = 5'h02;
    localparam logic [IDX_W-1:0] IDX_PERIPHERAL_IRQ_ENABLE_2 = 5'h03;
    localparam logic [IDX_W-1:0] IDX_PWR_STATUS = 5'h04;
    localparam logic [IDX_W-1:0] IDX_AUX_FLAGS = 5'h05;
    localparam logic [IDX_W-1:0] IDX_TMR_PERIOD = 5'h06;
    localparam logic [IDX_W-1:0] IDX_SER_ADDR = 5'h07;
    localparam logic [IDX_W-1:0] IDX_SER_STATE = 5'h08;
    localparam logic [IDX_W-1:0] IDX_TX_CTRL = 5'h09;
    localparam logic [IDX_W-1:0] IDX_BAUD_DIV = 5'h0a;
    localparam logic [IDX_W-1:0] IDX_IRQ_CORE = 5'h0b;
    localparam logic [IDX_W-1:0] IDX_PERIPHERAL_IRQ_FLAGS_1 = 5'h0c;
    localparam logic [IDX_W-1:0] IDX_PERIPHERAL_IRQ_FLAGS_2 = 5'h0d;
    localparam logic [IDX_W-1:0] IDX_NONE = 5'h1f;

    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h38;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h3c;
    localparam logic [ADDR_W-1:0] OFF_CAUSE = 8'h40;

    // ==========================================================
    // field positions
    // ==========================================================
    localparam int GIE_BIT = 7;
    localparam int ST_POR = 0;
    localparam int ST_MASTER_CLEAR_PIN = 1;
    localparam int ST_WAKE = 2;
    localparam int ST_VECTOR = 3;
    localparam int ST_W = 4;

    // ==========================================================
    // value columns, index 13 leftmost down to index 0
    // ==========================================================
    typedef logic [SFR_N-1:0][7:0] sfr_arr_t;

    localparam sfr_arr_t IMPL_MASK = '{8'h01, 8'hff, 8'hff, 8'hff,
        8'hf7, 8'h3f, 8'hff, 8'hff, 8'h02, 8'h03, 8'h01, 8'hff,
        8'hf7, 8'hff};
    localparam sfr_arr_t RESET_VAL = '{8'h00, 8'h00, 8'h00, 8'h00,
        8'h02, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h07, 8'hff};
    localparam sfr_arr_t KEEP_POR = '{8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00,
        8'h00, 8'h00};
    localparam sfr_arr_t KEEP_MASTER_CLEAR_PIN = '{8'h00, 8'h00, 8'h01, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h03, 8'h00, 8'h00,
        8'h00, 8'h00};
    localparam sfr_arr_t KEEP_WAKE = '{8'hff, 8'hff, 8'hff, 8'hff,
        8'hff, 8'hff, 8'hff, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff,
        8'hff, 8'hff};

    localparam logic [15:0] IRQ_VECTOR = 16'h0004;

    // ==========================================================
    // carriers
    // ==========================================================
    typedef enum logic [1:0] {
        CLS_NONE,
        CLS_POR,
        CLS_MASTER_CLEAR_PIN,
        CLS_WAKE
    } cause_cls_t;

    typedef struct packed {
        logic [1:0] reg_sel;
        logic [2:0] bit_sel;
    } wake_src_t;

    localparam logic [1:0] SRC_IRQ_CORE = 2'h0;
    localparam logic [1:0] SRC_PERIPHERAL_IRQ_FLAGS_1 = 2'h1;
    localparam logic [1:0] SRC_PERIPHERAL_IRQ_FLAGS_2 = 2'h2;

endpackage

/* sim/core_model.sv */
`timescale 1ns/1ps
module core_model (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic exec_next,
    input wire logic slow,
    output logic core_step
);
    // ==========================================================
    // core: runs pc+1, then reports it
    // ==========================================================
    initial core_step = 1'b0;
    always @(posedge ref_clk) begin
        if (rst_b && exec_next === 1'b1) begin
            repeat (slow ? 4 : 1) @(posedge ref_clk);
            core_step <= 1'b1;
            @(posedge ref_clk);
            core_step <= 1'b0;
        end
    end
endmodule

/* sim/rsi_monitor.sv */
`timescale 1ns/1ps
module rsi_monitor import rsi_pkg::*; #(
    parameter int PC_W = 13
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic por_bor_evt,
    input wire logic master_clear_pin_evt,
    input wire logic wdt_rst_evt,
    input wire logic wake_irq_evt,
    input wire logic wake_wdt_evt,
    input wire logic core_step,
    input wire logic psel,
    input wire logic penable,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire sfr_arr_t sfr_state,
    input wire logic exec_next,
    input wire logic vector_load,
    input wire logic [PC_W-1:0] vector_addr
);
    // ==========================================================
    // checks
    // ==========================================================
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    logic rst_e;
    logic wake_e;
    assign rst_e = (por_bor_evt | master_clear_pin_evt | wdt_rst_evt) & clk_en;
    assign wake_e = (wake_irq_evt | wake_wdt_evt) & clk_en & ~rst_e;

    apb_answer_a: assert property (psel && !penable && clk_en |=> pready)
        else $error("no answer after setup");
    ready_pulse_a: assert property (pready && clk_en |=> !pready)
        else $error("ready longer than one cycle");
    err_zero_a: assert property (pslverr |-> prdata == '0)
        else $error("error with data");
    reset_dirs_a: assert property (rst_e |-> ##2
        sfr_state[0] == 8'hff && sfr_state[1] == 8'h07 &&
        sfr_state[9] == 8'h02) else $error("reset pattern wrong");
    reset_clear_a: assert property (rst_e |-> ##2
        (sfr_state[2] | sfr_state[3] | sfr_state[7] | sfr_state[8] |
        sfr_state[10]) == 8'h00) else $error("reset clear wrong");
    gie_clear_a: assert property (rst_e |-> ##2 !sfr_state[11][GIE_BIT])
        else $error("global enable kept");
    por_power_a: assert property (por_bor_evt && clk_en |-> ##2
        !sfr_state[4][1] && !sfr_state[5][1]) else $error("power bits");
    timer_ones_a: assert property (rst_e || wake_e |-> ##2
        sfr_state[6] == 8'hff) else $error("timer period not ones");
    impl_zero_a: assert property ((sfr_state & ~IMPL_MASK) == '0)
        else $error("unimplemented bit set");
    wake_flag_a: assert property (wake_irq_evt && wake_e |-> ##2
        (sfr_state[11] | sfr_state[12] | sfr_state[13]) != 8'h00)
        else $error("no wake flag");
    exec_cause_a: assert property (exec_next |-> $past(wake_irq_evt, 2))
        else $error("exec without wake");
    vector_order_a: assert property (vector_load |-> $past(core_step) &&
        vector_addr == PC_W'(IRQ_VECTOR)) else $error("vector wrong");

    cover property (rst_e);
    cover property (wake_e);
    cover property (vector_load);
    cover property (pslverr);
endmodule

bind reset_state_initializer rsi_monitor #(.PC_W(PC_W)) i_mon (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .por_bor_evt(por_bor_evt),
    .master_clear_pin_evt(master_clear_pin_evt),
    .wdt_rst_evt(wdt_rst_evt),
    .wake_irq_evt(wake_irq_evt),
    .wake_wdt_evt(wake_wdt_evt),
    .core_step(core_step),
    .psel(psel),
    .penable(penable),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .sfr_state(sfr_state),
    .exec_next(exec_next),
    .vector_load(vector_load),
    .vector_addr(vector_addr)
);

/* sim/testbench.sv */
`timescale 1ns/1ps
module testbench import rsi_pkg::*;;
    logic ref_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, d;
    logic pready, pslverr, er, exec_next, vector_load, irq, c, x, ce = 1;
    logic core_step, slow = 0;
    logic [4:0] ev = 0;
    logic [3:0] st, m;
    logic [12:0] vector_addr;
    wake_src_t src = '0;
    sfr_arr_t sfr_state, exp;
    int error_cnt = 0, n_tests = 0, it, i, e;

    reset_state_initializer i_dut (.ref_clk(ref_clk), .rst_b(rst_b),
        .clk_en(ce), .por_bor_evt(ev[0]), .master_clear_pin_evt(ev[1]),
        .wdt_rst_evt(ev[2]), .wake_irq_evt(ev[3]), .wake_wdt_evt(ev[4]),
        .wake_src(src), .core_step(core_step), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sfr_state(sfr_state), .exec_next(exec_next),
        .vector_load(vector_load), .vector_addr(vector_addr), .irq(irq));
    core_model i_core (.ref_clk(ref_clk), .rst_b(rst_b),
        .exec_next(exec_next), .slow(slow), .core_step(core_step));

    initial forever #2.5 ref_clk = ~ref_clk;

    // ==========================================================
    // helpers
    // ==========================================================
    task chk(input string nm, input logic [111:0] g, x);
        n_tests++;
        if (g !== x) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", nm, x, g);
        end
    endtask

    task close_out;
        $display("tests %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] dd);
        int n;
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= dd;
        @(posedge ref_clk);
        penable <= 1;
        for (n = 0; n < 20; n++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        if (n == 20) begin
            error_cnt++;
            close_out;
        end
        @(posedge ref_clk);
    endtask

    task rdall;
        for (i = 0; i < 14; i++) begin
            apb(0, 8'(4 * i), 0);
            chk("sfr read", rd, 32'(exp[i]));
        end
    endtask

    task fire(input int k);
        ev <= 5'(1 << k);
        src <= wake_src_t'($urandom);
        @(posedge ref_clk);
        ev <= 0;
        @(posedge ref_clk);
    endtask

    function automatic sfr_arr_t nxt(sfr_arr_t cur, int k, wake_src_t s);
        sfr_arr_t kp, r;
        kp = k == 0 ? KEEP_POR : k < 3 ? KEEP_MASTER_CLEAR_PIN : KEEP_WAKE;
        r = (cur & kp) | (RESET_VAL & ~kp);
        if (k == 3)
            r[s.reg_sel > 1 ? 13 : 11 + s.reg_sel]
                [s.reg_sel > 1 ? 0 : s.bit_sel] = 1'b1;
        return r & IMPL_MASK;
    endfunction

    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        it = $urandom(32'hfcaf);
        exp = RESET_VAL;
        repeat (20) @(posedge ref_clk);
        rst_b <= 1;
        @(posedge ref_clk);
        chk("reset", sfr_state, RESET_VAL);
        rdall;
        for (it = 0; it < 40; it++) begin
            for (i = 0; i < 14; i++) begin
                d = $urandom;
                apb(1, 8'(4 * i), d);
                exp[i] = d[7:0] & IMPL_MASK[i];
            end
            m = 4'($urandom);
            apb(1, 8'h3c, 32'(m));
            rdall;
            e = it < 5 ? it : $urandom % 5;
            slow <= it[0];
            c = exp[11][GIE_BIT] && e == 3;
            fire(e);
            exp = nxt(exp, e, src);
            st = e == 0 ? 4'h1 : e < 3 ? 4'h2 : 4'h4;
            x = 0;
            if (c) begin
                for (i = 0; i < 20 && vector_load !== 1'b1; i++) begin
                    @(posedge ref_clk);
                    x |= exec_next === 1'b1;
                end
                if (i == 20) begin
                    error_cnt++;
                    close_out;
                end
                chk("vector load", vector_load, 1);
                chk("vector addr", vector_addr, 13'h0004);
                st[3] = 1'b1;
            end
            repeat (3) begin
                @(posedge ref_clk);
                x |= exec_next === 1'b1;
            end
            chk("exec next", x, c);
            chk("sfr", sfr_state, exp);
            chk("irq", irq, |(st & m));
            apb(0, 8'h38, 0);
            chk("status", rd, 32'(st));
            repeat (2) @(posedge ref_clk);
            chk("irq clear", irq, 0);
            apb(0, OFF_CAUSE, 0);
            chk("cause", rd, e == 0 ? 1 : e < 3 ? 2 : 3);
        end
        ce <= 0;
        fire(0);
        ce <= 1;
        @(posedge ref_clk);
        chk("frozen", sfr_state, exp);
        apb(0, 8'h44, 0);
        chk("unmapped", {er, rd}, 33'h1_0000_0000);
        apb(1, 8'h02, 32'h0000_00aa);
        chk("unaligned", er, 1);
        apb(0, 8'h00, 0);
        chk("no write", rd, 32'(exp[0]));
        rst_b <= 0;
        repeat (2) @(posedge ref_clk);
        chk("second reset", sfr_state, RESET_VAL);
        rst_b <= 1;
        @(posedge ref_clk);
        close_out;
    end
endmodule
